// ---- shared/pdc_defs.svh ----
// Offsets, field positions, reset values and timing counts of the PWM block
`ifndef PDC_DEFS_SVH
`define PDC_DEFS_SVH

`define PDC_OFS_CTRL      12'h000
`define PDC_OFS_PERIOD    12'h004
`define PDC_OFS_MASTER    12'h008
`define PDC_OFS_STATUS    12'h00C
`define PDC_GEN_FIRST     8'h01
`define PDC_SUB_DUTY      4'h0
`define PDC_SUB_DT        4'h4
`define PDC_SUB_ALT       4'h8
`define PDC_SUB_GCTL      4'hC

`define PDC_CTRL_RUN      0
`define PDC_CTRL_DEFER    1
`define PDC_GCTL_MASTER   0
`define PDC_GCTL_INDOUT   1
`define PDC_GCTL_INDTB    2
`define PDC_GCTL_DTM      3
`define PDC_GCTL_PHASE    16
`define PDC_STAT_HIGH     8
`define PDC_STAT_LOW      16

`define PDC_DTM_POS       2'h0
`define PDC_DTM_NEG       2'h1
`define PDC_DTM_OFF       2'h2
`define PDC_DTM_DUAL      2'h3

`define PDC_RST_PERIOD    16'hFFF8
`define PDC_RST_DUTY      16'h0000
`define PDC_RST_DT        12'h000
`define PDC_DUTY_FULL     16'hFFFF

`define PDC_TB_HZ          120000000
`define PDC_PCLK_HZ        50000000
`define PDC_DUTY_STEP_PS   1050
`define PDC_PERIOD_STEP_PS 8400
`define PDC_TB_DIV         ((`PDC_PCLK_HZ + `PDC_TB_HZ - 1) / `PDC_TB_HZ)

`endif

// ---- shared/pdc_pkg.sv ----
// Types and helper functions of the PWM block
`include "pdc_defs.svh"
package pdc_pkg;
	typedef logic [15:0] pdc_word_t;
	typedef logic [12:0] pdc_tb_t;
	typedef logic [11:0] pdc_dt_t;
	typedef enum logic {edge_rise, edge_fall} pdc_edge_e;

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_w, input logic [31:0] new_w,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old_w;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				r[8*i +: 8] = new_w[8*i +: 8];
		end
		return r;
	endfunction

	// Values below one whole count give no pulse at all
	function automatic logic duty_hit(input pdc_word_t duty, input pdc_tb_t count);
		if (duty == `PDC_DUTY_FULL)
			return 1'b1;
		else if (duty[15:3] == 13'h0000)
			return 1'b0;
		else
			return count <= duty[15:3];
	endfunction

	// Bit 0 goes to the fine delay; edge cycle itself counts as one
	function automatic pdc_dt_t dt_load(input pdc_dt_t v);
		pdc_dt_t half;
		half = {1'b0, v[11:1]};
		return (half == 12'h000) ? 12'h000 : half - 12'h001;
	endfunction
endpackage

// ---- design/pdc_compare.sv ----
// Local time base and duty comparison of one generator
`timescale 1ns/1ns
`include "pdc_defs.svh"
module pdc_compare (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              tick,
	input  wire logic              run,
	input  wire logic              rollover,
	input  wire logic              indep_tb,
	input  wire pdc_pkg::pdc_word_t phase,
	input  wire pdc_pkg::pdc_word_t duty,
	output pdc_pkg::pdc_tb_t        local_time_count,
	output logic                    active
);
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			local_time_count <= 13'h0000;
		else if (!run)
			local_time_count <= 13'h0000;
		else if (tick)
		begin
			if (indep_tb)
				local_time_count <= (local_time_count == phase[15:3]) ? 13'h0000 : local_time_count + 13'h0001;
			else if (rollover)
				local_time_count <= phase[15:3];
			else
				local_time_count <= local_time_count + 13'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			active <= 1'b0;
		else if (!run)
			active <= 1'b0;
		else
			active <= pdc_pkg::duty_hit(duty, local_time_count);
	end

	AST_DUTY_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		duty == `PDC_RST_DUTY |=> !active) else $error("zero duty gave a pulse");
	AST_DUTY_FULL: assert property (@(posedge pclk) disable iff (!presetn)
		run && duty == `PDC_DUTY_FULL |=> active) else $error("full duty went low");
	AST_DUTY_LE: assert property (@(posedge pclk) disable iff (!presetn)
		run && duty[15:3] != 13'h0000 && duty != `PDC_DUTY_FULL
		|=> active == ($past(local_time_count) <= $past(duty[15:3]))) else $error("compare wrong");
	AST_TB_STEP: assert property (@(posedge pclk) disable iff (!presetn)
		run && tick && !indep_tb && !rollover |=> local_time_count == $past(local_time_count) + 13'h0001)
		else $error("local count did not advance");
endmodule

// ---- design/pdc_deadtime.sv ----
// Dead-time unit and output steering of one pin pair
`timescale 1ns/1ns
`include "pdc_defs.svh"
module pdc_deadtime (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             tick,
	input  wire logic             run,
	input  wire logic             active,
	input  wire logic [1:0]       deadtime_mode_select,
	input  wire logic             indep_out,
	input  wire pdc_pkg::pdc_dt_t generator_deadtime_value,
	input  wire pdc_pkg::pdc_dt_t alternate_deadtime_value,
	output logic                  high_side_output,
	output logic                  low_side_output,
	output logic                  fine_dt
);
	logic                  act_d;
	pdc_pkg::pdc_dt_t      cnt;
	pdc_pkg::pdc_edge_e    ph;
	logic                  rise;
	logic                  fall;
	logic                  rise_blk;
	logic                  fall_blk;
	logic                  next_high;
	logic                  next_low;
	pdc_pkg::pdc_dt_t      fall_val;

	assign rise     = tick & active & ~act_d;
	assign fall     = tick & ~active & act_d;
	assign fall_val = (deadtime_mode_select == `PDC_DTM_DUAL) ? alternate_deadtime_value : generator_deadtime_value;
	assign rise_blk = rise | (cnt != 12'h000 && ph == pdc_pkg::edge_rise);
	assign fall_blk = fall | (cnt != 12'h000 && ph == pdc_pkg::edge_fall);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			act_d <= 1'b0;
			cnt   <= `PDC_RST_DT;
			ph    <= pdc_pkg::edge_rise;
		end
		else if (!run)
		begin
			act_d <= 1'b0;
			cnt   <= `PDC_RST_DT;
		end
		else if (tick)
		begin
			act_d <= active;
			if (rise)
			begin
				cnt <= pdc_pkg::dt_load(generator_deadtime_value);
				ph  <= pdc_pkg::edge_rise;
			end
			else if (fall)
			begin
				cnt <= pdc_pkg::dt_load(fall_val);
				ph  <= pdc_pkg::edge_fall;
			end
			else if (cnt != 12'h000)
				cnt <= cnt - 12'h001;
		end
	end

	always_comb
	begin
		case (deadtime_mode_select)
			`PDC_DTM_OFF:
			begin
				next_high = active;
				next_low  = ~active;
			end
			`PDC_DTM_NEG:
			begin
				next_high = active | fall_blk;
				next_low  = ~active | rise_blk;
			end
			default:
			begin
				next_high = active & ~rise_blk;
				next_low  = ~active & ~fall_blk;
			end
		endcase
		if (indep_out)
			next_low = next_high;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			high_side_output <= 1'b0;
			low_side_output  <= 1'b0;
			fine_dt          <= 1'b0;
		end
		else if (!run)
		begin
			high_side_output <= 1'b0;
			low_side_output  <= 1'b0;
			fine_dt          <= 1'b0;
		end
		else
		begin
			high_side_output <= next_high;
			low_side_output  <= next_low;
			fine_dt          <= rise ? generator_deadtime_value[0] : fall ? fall_val[0] : fine_dt;
		end
	end

	AST_COMP_INV: assert property (@(posedge pclk) disable iff (!presetn)
		run && deadtime_mode_select == `PDC_DTM_OFF && !indep_out
		|=> high_side_output == $past(active) && low_side_output == !$past(active)) else $error("pair not inverse");
	AST_INDEP_SAME: assert property (@(posedge pclk) disable iff (!presetn)
		run && indep_out && deadtime_mode_select == `PDC_DTM_OFF
		|=> high_side_output == $past(active) && low_side_output == $past(active)) else $error("pins differ");
	AST_POS_DELAY: assert property (@(posedge pclk) disable iff (!presetn)
		run && rise && deadtime_mode_select == `PDC_DTM_POS |=> !high_side_output) else $error("no dead time");
	AST_NEG_OVERLAP: assert property (@(posedge pclk) disable iff (!presetn)
		run && rise && deadtime_mode_select == `PDC_DTM_NEG && !indep_out
		|=> high_side_output && low_side_output) else $error("no overlap");
	AST_NO_SHOOT: assert property (@(posedge pclk) disable iff (!presetn)
		deadtime_mode_select == `PDC_DTM_POS && !indep_out && $past(deadtime_mode_select) == `PDC_DTM_POS
		&& !$past(indep_out)
		|-> !(high_side_output && low_side_output)) else $error("shoot-through");
endmodule

// ---- design/pdc_pwm.sv ----
// PWM duty comparison and dead-time block with APB registers
//
// Behaviour
// - One duty step is 1.05 ns, one period step 8.4 ns.
// - Time base nominally 120 MHz; frequency step is clock over period.
// - Two to four generators, private duty, optional shared master duty.
// - Thirteen-bit counters advance one count per time-base tick.
// - Output asserted while count is at most upper 13 duty bits.
// - Lowest three duty bits go to fine edge adjustment.
// - Duty writes any time; optional hold until primary rollover.
// - Complementary mode drives inverse of active signal on second pin.
// - Complementary outputs offered except push-pull and independent modes.
// - Independent output mode drives same signal on both pins.
// - Duty 0x0008 is the smallest value giving a pulse.
// - Duty 0x0000 holds output low, 0xFFFF holds it high.
// - Output waits until its complement has been off the dead time.
// - Dead time available on every pair in any output mode.
// - Negative dead time overlaps both outputs for the interval.
// - Two-bit field selects dead-time mode, disabled gives zero.
// - Edge detectors and 12-bit down counters delay transitions.
// - Alternate dead time applies to the complementary edge.
// - Twelve-bit dead time; lowest bit to fine adjustment.
// - Period match clears primary count and reloads phases of generators without independent time base.
// - Clearing run enable stops and clears all counters.
`timescale 1ns/1ns
`include "pdc_defs.svh"
module pdc_pwm #(
	parameter int NGEN   = 4,
	parameter int TB_DIV = `PDC_TB_DIV
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	input  wire logic [3:0]          pstrb,
	output logic [31:0]              prdata,
	output logic                     pready,
	output logic                     pslverr,
	output logic [NGEN-1:0]          high_side_output,
	output logic [NGEN-1:0]          low_side_output,
	output logic [3*NGEN-1:0]        fine_duty_adj,
	output logic [NGEN-1:0]          fine_deadtime_adj
);
	localparam logic [7:0] NG8 = 8'(NGEN);
	localparam logic [7:0] DV8 = 8'(TB_DIV);

	logic                 module_run_enable;
	logic                 defer_duty;
	pdc_pkg::pdc_word_t   primary_period_value;
	pdc_pkg::pdc_tb_t     primary_time_count;
	pdc_pkg::pdc_word_t   master_pend;
	pdc_pkg::pdc_word_t   master_act;
	pdc_pkg::pdc_word_t   duty_pend [NGEN];
	pdc_pkg::pdc_word_t   duty_act [NGEN];
	pdc_pkg::pdc_word_t   phase [NGEN];
	pdc_pkg::pdc_dt_t     deadtime [NGEN];
	pdc_pkg::pdc_dt_t     alt_deadtime [NGEN];
	logic [1:0]           dt_mode [NGEN];
	logic [NGEN-1:0]      use_master;
	logic [NGEN-1:0]      indep_out;
	logic [NGEN-1:0]      indep_tb;
	logic [NGEN-1:0]      active;
	logic [7:0]           div_cnt;
	logic                 tick;
	logic                 rollover;
	logic                 is_gen;
	logic [7:0]           gidx;
	logic [1:0]           gi;
	logic                 mapped;
	logic                 wr;
	logic [31:0]          cur_word;
	logic [31:0]          wword;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_cnt <= 8'h00;
		else if (!module_run_enable || div_cnt == DV8 - 8'h01)
			div_cnt <= 8'h00;
		else
			div_cnt <= div_cnt + 8'h01;
	end
	assign tick = module_run_enable && div_cnt == 8'h00;

	assign rollover = tick && primary_time_count == primary_period_value[15:3];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			primary_time_count <= 13'h0000;
		else if (!module_run_enable)
			primary_time_count <= 13'h0000;
		else if (rollover)
			primary_time_count <= 13'h0000;
		else if (tick)
			primary_time_count <= primary_time_count + 13'h0001;
	end

	// Address decode
	assign gidx   = paddr[11:4] - `PDC_GEN_FIRST;
	assign gi     = gidx[1:0];
	assign is_gen = paddr[11:4] >= `PDC_GEN_FIRST && gidx < NG8 && paddr[1:0] == 2'h0;
	assign mapped = is_gen || paddr == `PDC_OFS_CTRL || paddr == `PDC_OFS_PERIOD
		|| paddr == `PDC_OFS_MASTER || paddr == `PDC_OFS_STATUS;
	assign wr      = psel && penable && pwrite && mapped;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign wword   = pdc_pkg::merge_bytes(cur_word, pwdata, pstrb);

	// Current word of the addressed register
	always_comb
	begin
		cur_word = 32'h0000_0000;
		case (paddr)
			`PDC_OFS_CTRL:
			begin
				cur_word[`PDC_CTRL_RUN]   = module_run_enable;
				cur_word[`PDC_CTRL_DEFER] = defer_duty;
			end
			`PDC_OFS_PERIOD:
				cur_word[15:0] = primary_period_value;
			`PDC_OFS_MASTER:
				cur_word[15:0] = master_pend;
			`PDC_OFS_STATUS:
			begin
				cur_word[`PDC_CTRL_RUN] = module_run_enable;
				for (int g = 0; g < NGEN; g++)
				begin
					cur_word[`PDC_STAT_HIGH + g] = high_side_output[g];
					cur_word[`PDC_STAT_LOW + g]  = low_side_output[g];
				end
			end
			default:
			begin
				if (is_gen)
				begin
					case (paddr[3:0])
						`PDC_SUB_DUTY:
							cur_word[15:0] = duty_pend[gi];
						`PDC_SUB_DT:
							cur_word[11:0] = deadtime[gi];
						`PDC_SUB_ALT:
							cur_word[11:0] = alt_deadtime[gi];
						default:
						begin
							cur_word[`PDC_GCTL_MASTER]      = use_master[gi];
							cur_word[`PDC_GCTL_INDOUT]      = indep_out[gi];
							cur_word[`PDC_GCTL_INDTB]       = indep_tb[gi];
							cur_word[`PDC_GCTL_DTM +: 2]    = dt_mode[gi];
							cur_word[`PDC_GCTL_PHASE +: 16] = phase[gi];
						end
					endcase
				end
			end
		endcase
	end

	// Read data captured in setup so it comes from a flop
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata <= cur_word;
	end

	// Module control and period
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			module_run_enable    <= 1'b0;
			defer_duty           <= 1'b0;
			primary_period_value <= `PDC_RST_PERIOD;
		end
		else if (wr && paddr == `PDC_OFS_CTRL)
		begin
			module_run_enable <= wword[`PDC_CTRL_RUN];
			defer_duty        <= wword[`PDC_CTRL_DEFER];
		end
		else if (wr && paddr == `PDC_OFS_PERIOD)
			primary_period_value <= wword[15:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			master_pend <= `PDC_RST_DUTY;
			for (int g = 0; g < NGEN; g++)
				duty_pend[g] <= `PDC_RST_DUTY;
		end
		else if (wr)
		begin
			if (paddr == `PDC_OFS_MASTER)
				master_pend <= wword[15:0];
			if (is_gen && paddr[3:0] == `PDC_SUB_DUTY)
				duty_pend[gi] <= wword[15:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			master_act <= `PDC_RST_DUTY;
			for (int g = 0; g < NGEN; g++)
				duty_act[g] <= `PDC_RST_DUTY;
		end
		else if (!defer_duty || rollover)
		begin
			master_act <= master_pend;
			for (int g = 0; g < NGEN; g++)
				duty_act[g] <= duty_pend[g];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int g = 0; g < NGEN; g++)
			begin
				deadtime[g]     <= `PDC_RST_DT;
				alt_deadtime[g] <= `PDC_RST_DT;
				dt_mode[g]      <= `PDC_DTM_POS;
				phase[g]        <= 16'h0000;
			end
			use_master <= '0;
			indep_out  <= '0;
			indep_tb   <= '0;
		end
		else if (wr && is_gen)
		begin
			case (paddr[3:0])
				`PDC_SUB_DT:
					deadtime[gi] <= wword[11:0];
				`PDC_SUB_ALT:
					alt_deadtime[gi] <= wword[11:0];
				`PDC_SUB_GCTL:
				begin
					use_master[gi] <= wword[`PDC_GCTL_MASTER];
					indep_out[gi]  <= wword[`PDC_GCTL_INDOUT];
					indep_tb[gi]   <= wword[`PDC_GCTL_INDTB];
					dt_mode[gi]    <= wword[`PDC_GCTL_DTM +: 2];
					phase[gi]      <= wword[`PDC_GCTL_PHASE +: 16];
				end
				default:
					phase[gi] <= phase[gi];
			endcase
		end
	end

	// Per-generator compare and dead-time units
	for (genvar g = 0; g < NGEN; g++)
	begin : gen_unit
		pdc_pkg::pdc_word_t sel_duty;
		assign sel_duty = use_master[g] ? master_act : duty_act[g];

		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
				fine_duty_adj[3*g +: 3] <= 3'h0;
			else
				fine_duty_adj[3*g +: 3] <= module_run_enable ? sel_duty[2:0] : 3'h0;
		end

		pdc_compare u_cmp (
			.pclk             (pclk),
			.presetn          (presetn),
			.tick             (tick),
			.run              (module_run_enable),
			.rollover         (rollover),
			.indep_tb         (indep_tb[g]),
			.phase            (phase[g]),
			.duty             (sel_duty),
			.local_time_count (),
			.active           (active[g])
		);

		pdc_deadtime u_dt (
			.pclk                     (pclk),
			.presetn                  (presetn),
			.tick                     (tick),
			.run                      (module_run_enable),
			.active                   (active[g]),
			.deadtime_mode_select     (dt_mode[g]),
			.indep_out                (indep_out[g]),
			.generator_deadtime_value (deadtime[g]),
			.alternate_deadtime_value (alt_deadtime[g]),
			.high_side_output         (high_side_output[g]),
			.low_side_output          (low_side_output[g]),
			.fine_dt                  (fine_deadtime_adj[g])
		);
	end

	AST_PERIOD_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
		rollover && module_run_enable |=> primary_time_count == 13'h0000) else $error("no wrap at period");
	AST_RUN_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
		!module_run_enable |=> primary_time_count == 13'h0000) else $error("count not cleared");
	AST_TB_ADV: assert property (@(posedge pclk) disable iff (!presetn)
		module_run_enable && tick && !rollover |=> primary_time_count == $past(primary_time_count) + 13'h0001)
		else $error("primary count stuck");
	AST_DEFER_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		defer_duty && !rollover |=> duty_act[0] == $past(duty_act[0])) else $error("duty applied early");
	AST_IDLE_OUT: assert property (@(posedge pclk) disable iff (!presetn)
		!module_run_enable ##1 !module_run_enable |-> high_side_output == '0 && low_side_output == '0)
		else $error("output active while stopped");
endmodule

// ---- dv/pdc_gate_model.sv ----
// Gate driver model counting pin states of one output pair
`timescale 1ns/1ns
module pdc_gate_model (
	input  wire logic       pclk,
	input  wire logic       clr,
	input  wire logic       hs,
	input  wire logic       ls,
	output logic [7:0]      n_hi,
	output logic [7:0]      n_lo,
	output logic [7:0]      n_both
);
	// Overlap counted, not flagged: negative dead time is legal
	always @(posedge pclk)
	begin
		if (clr)
		begin
			n_hi <= 8'h00;
			n_lo <= 8'h00;
			n_both <= 8'h00;
		end
		else
		begin
			n_hi <= n_hi + 8'(hs);
			n_lo <= n_lo + 8'(ls);
			n_both <= n_both + 8'(hs & ls);
		end
	end
endmodule

// ---- dv/pdc_pwm_tb_top.sv ----
// Self-checking bench of the PWM compare and dead-time block
`timescale 1ns/1ns
`include "pdc_defs.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_total++; $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module pdc_pwm_tb_top;
	localparam int NGEN = 4;
	logic              pclk = 1'b0;
	logic              presetn = 1'b0;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [11:0]       paddr = 12'h000;
	logic [31:0]       pwdata = 32'h0000_0000;
	logic [3:0]        pstrb = 4'hF;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic [NGEN-1:0]   hso;
	logic [NGEN-1:0]   lso;
	logic [3*NGEN-1:0] fda;
	logic [NGEN-1:0]   fdt;
	logic              clr = 1'b0;
	logic [1:0]        sel = 2'h0;
	logic [7:0]        n_hi;
	logic [7:0]        n_lo;
	logic [7:0]        n_both;
	logic [32:0]       expq[$];
	logic [32:0]       ev;
	logic [31:0]       rnd = 32'h0001_5E57;
	logic [15:0]       d;
	int                err_total = 0;
	int                n_tests = 0;
	logic [15:0]       duty_tab[5] = '{16'h0000, 16'h0007, 16'h0008, 16'h0028, 16'hFFFF};
	logic [7:0]        hi_tab[5] = '{8'h00, 8'h00, 8'h04, 8'h0C, 8'h20};
	logic [1:0]        dtm_tab[3] = '{`PDC_DTM_POS, `PDC_DTM_NEG, `PDC_DTM_DUAL};
	logic [23:0]       dt_exp[3] = '{24'h0C_0C00, 24'h14_1408, 24'h0C_0E00};

	always #10 pclk = ~pclk;

	pdc_pwm #(.NGEN(NGEN), .TB_DIV(1)) u_pdc_pwm (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .high_side_output(hso),
		.low_side_output(lso), .fine_duty_adj(fda), .fine_deadtime_adj(fdt));

	pdc_gate_model u_pdc_gate_model (.pclk(pclk), .clr(clr), .hs(hso[sel]), .ls(lso[sel]),
		.n_hi(n_hi), .n_lo(n_lo), .n_both(n_both));

	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction

	task automatic print_verdict;
		if (err_total == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dat);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= dat;
		@(posedge pclk);
		penable <= 1'b1;
		// Slave latency not assumed
		for (k = 0; k < 50; k++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (k == 50)
		begin
			err_total++;
			$display("MISMATCH %0t no ready", $time);
			print_verdict();
		end
		else
		begin
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		expq.push_back(e);
		apb(1'b0, a, 32'h0000_0000);
	endtask

	// Counts over two whole periods, so the phase does not matter
	task automatic meas(input logic [1:0] g, input logic [23:0] e);
		@(posedge pclk);
		sel <= g;
		clr <= 1'b1;
		repeat (40) @(posedge pclk);
		clr <= 1'b0;
		repeat (32) @(posedge pclk);
		#1;
		`CHK({n_hi, n_lo, n_both}, e)
	endtask

	// Read results compared in order of issue
	always @(posedge pclk)
	begin
		if (psel && penable && pready && !pwrite)
		begin
			if (expq.size() == 0)
			begin
				err_total++;
				$display("MISMATCH %0t unexpected read", $time);
			end
			else
			begin
				ev = expq.pop_front();
				`CHK({pslverr, prdata}, ev)
			end
		end
	end

	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		`CHK({hso, lso, fda, fdt}, 24'h00_0000)
		rd(`PDC_OFS_PERIOD, {17'h0_0000, `PDC_RST_PERIOD});
		rd(12'h010, {17'h0_0000, `PDC_RST_DUTY});
		rd(12'hFF0, {1'b1, 32'h0000_0000});
		apb(1'b1, `PDC_OFS_PERIOD, 32'h0000_0078);
		apb(1'b1, 12'h01C, {27'h000_0000, `PDC_DTM_OFF, 3'h0});
		apb(1'b1, `PDC_OFS_CTRL, 32'h0000_0001);
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b1, 12'h010, {16'h0000, duty_tab[i]});
			meas(2'h0, {hi_tab[i], 8'h20 - hi_tab[i], 8'h00});
			`CHK(fda[2:0], duty_tab[i][2:0])
		end
		apb(1'b1, 12'h010, 32'h0000_0038);
		apb(1'b1, 12'h01C, {27'h000_0002, `PDC_DTM_OFF, 3'h2});
		meas(2'h0, 24'h10_1010);
		// dead times kept below a third of on and off time
		apb(1'b1, 12'h014, 32'h0000_0005);
		apb(1'b1, 12'h018, 32'h0000_0003);
		for (int i = 0; i < 3; i++)
		begin
			apb(1'b1, 12'h01C, {27'h000_0000, dtm_tab[i], 3'h0});
			meas(2'h0, dt_exp[i]);
			if (i == 0)
				`CHK(fdt[0], 1'b1)
		end
		apb(1'b1, `PDC_OFS_MASTER, 32'h0000_0040);
		apb(1'b1, 12'h02C, {27'h000_0000, `PDC_DTM_OFF, 3'h1});
		meas(2'h1, 24'h12_0E00);
		// random duty inside the legal range
		for (int i = 0; i < 3; i++)
		begin
			rnd = xs(rnd);
			d = 16'h0008 + 16'(rnd % 32'h0000_FFE8);
			apb(1'b1, 12'h030, {16'h0000, d});
			rd(12'h030, {17'h0_0000, d});
		end
		// long period so the next rollover is far off
		apb(1'b1, `PDC_OFS_PERIOD, {16'h0000, `PDC_RST_PERIOD});
		apb(1'b1, `PDC_OFS_CTRL, 32'h0000_0003);
		apb(1'b1, 12'h010, 32'h0000_0015);
		rd(12'h010, {17'h0_0000, 16'h0015});
		#1;
		`CHK(fda[2:0], 3'h0)
		repeat (8200) @(posedge pclk);
		#1;
		`CHK(fda[2:0], 3'h5)
		apb(1'b1, `PDC_OFS_CTRL, 32'h0000_0000);
		repeat (4) @(posedge pclk);
		`CHK({hso, lso, fda, fdt}, 24'h00_0000)
		rd(`PDC_OFS_STATUS, {1'b0, 32'h0000_0000});
		repeat (2) @(posedge pclk);
		`CHK(expq.size(), 0)
		print_verdict();
	end
endmodule
